//--- inc/audio_port_regs.vh
`ifndef AUDIO_PORT_REGS_VH
`define AUDIO_PORT_REGS_VH
// apb byte offsets
`define OFF_PDM_CTRL     8'h00
`define OFF_RX_CTRL      8'h04
`define OFF_RATE_CTRL    8'h08
`define OFF_STATUS       8'h0C
`define OFF_PDM_DATA     8'h10
`define OFF_RX_SAMPLE    8'h14
// pdm control fields
`define PDM_CAPTURE_EDGE_SEL_BIT     0
`define PDM_ROLE_BIT     1
`define PDM_MASTER_CLOCK_GATE_BIT     2
`define PDM_CLKSEL_BIT   3
`define PDM_RATE_LSB     4
`define PDM_PIN_ROLE_SELECT_BIT      6
`define PDM_CTRL_RESET   7'h08
// receive control fields
`define RX_EDGE_BIT      0
`define RX_FSTART_BIT    1
`define RECEIVE_SLOT_LENGTH_LSB      2
`define RX_OFFSET_LSB    4
`define RX_SLOT_LSB      9
`define RX_CTRL_RESET    13'h000A
// rate control fields
`define AUTO_RATE_BIT    0
`define SRATE_LSB        1
`define RATE_CTRL_RESET  4'h6
`define SRATE_1X         3'h3
`define SRATE_2X         3'h4
`define SRATE_4X         3'h5
`define SLEN_16          2'h0
`define SLEN_24          2'h1
`define SLEN_32          2'h2
// pdm clock half period in system cycles (20 MHz / (2*N)), base and double
`define PDM_HALF_1X      8'h04
`define PDM_HALF_2X      8'h02
// ramp counter wrap value; one volume step every 17 system cycles
`define RAMP_STEP        8'h10
`endif

//--- design/audio_input_port.v
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "audio_port_regs.vh"

// Function
// - capture pdm on both clock edges
// - capture edge select, rising default
// - pdm clock pin slave or master
// - gated master clock drives zero
// - clock select ground stops sampling
// - master clock fifty percent duty
// - two bit pdm rate select
// - pdm pin routed sensor or playback
// - slot counts per sample rate
// - slot widths 16 24 32
// - slot count detected automatically
// - auto rate enable, default on
// - manual sample rate code select
// - ramp down on clock fault
// - ramp back up on valid clocks
// - frame start edge select
// - receive edge select
// - five bit receive slot offset
// - mono playback in, sense stream out held low
// - receive edge zero rising default
// - receive slot length code
// - slot beyond frame gives null
module audio_input_port #(
    parameter SAMPLE_W = 32
) (
    input  wire        i_clock,        // 20 MHz system clock
    input  wire        i_reset_n,      // synchronous reset, active low
    input  wire        i_psel,         // apb select
    input  wire        i_penable,      // apb enable
    input  wire        i_pwrite,       // apb write
    input  wire [7:0]  i_paddr,        // apb byte address
    input  wire [31:0] i_pwdata,       // apb write data
    output reg         o_pready,       // apb ready
    output reg  [31:0] o_prdata,       // apb read data
    output reg         o_pslverr,      // apb error
    input  wire        i_serial_bit_clock, // host bit clock
    input  wire        i_frame_sync,   // host frame sync
    input  wire        i_serial_data_in, // playback data
    output reg         o_serial_data_out, // sense stream out
    input  wire        i_pdm_clock_pin, // pdm clock in (slave)
    output reg         o_pdm_clock_pin, // pdm clock out (master)
    output reg         o_pdm_clock_oe, // high while driving clock
    input  wire        i_pdm_data_pin, // pdm data
    output reg  [SAMPLE_W-1:0] o_play_sample, // playback sample
    output reg         o_play_valid,   // one-cycle sample strobe
    output reg  [7:0]  o_volume,       // playback gain, ramped
    output reg  [1:0]  o_pdm_play_bits, // pdm pair to playback
    output reg  [1:0]  o_pdm_sense_bits, // pdm pair to sensor
    output reg         o_pdm_valid     // pdm pair strobe
);
    reg  [6:0]  pdm_ctrl;
    reg  [12:0] rx_ctrl;
    reg  [3:0]  rate_ctrl;
    reg         clock_fault;
    reg  [2:0]  sync_bclk;
    reg  [2:0]  sync_fs;
    reg  [2:0]  sync_din;
    reg  [2:0]  sync_pck;
    reg  [2:0]  sync_pd;
    reg         bclk_lvl;
    reg         pck_lvl;
    reg         fs_prev;
    reg  [8:0]  bit_cnt;
    reg  [8:0]  frame_len;
    reg  [8:0]  frame_sys_cnt;
    reg  [12:0] fs_period;
    reg  [5:0]  slot_pos;
    reg  [SAMPLE_W-1:0] shreg;
    reg  [5:0]  slot_bit;
    reg  [3:0]  slot_idx;
    reg         pdm_rise_bit;
    reg  [7:0]  pdm_div;
    reg  [7:0]  ramp_cnt;
    reg  [7:0]  target_vol;
    wire        bclk_agree = (sync_bclk[1] == sync_bclk[2]);
    wire        pck_agree  = (sync_pck[1] == sync_pck[2]);
    wire        rx_edge    = rx_ctrl[`RX_EDGE_BIT];
    wire        master     = pdm_ctrl[`PDM_ROLE_BIT];
    wire        apb_acc    = i_psel & i_penable;
    wire        apb_wr     = apb_acc & i_pwrite;
    reg  [5:0]  slot_len;
    reg  [2:0]  eff_rate;
    reg         ratio_ok;
    reg         rate_ok;
    reg  [31:0] next_rdata;
    reg         addr_ok;
    // bit clock edge detect on agreeing samples
    wire bclk_new  = bclk_agree ? sync_bclk[2] : bclk_lvl;
    wire bclk_rise = ~bclk_lvl & bclk_new;
    wire bclk_fall = bclk_lvl & ~bclk_new;
    wire rx_strobe = rx_edge ? bclk_fall : bclk_rise;
    wire fs_now    = sync_fs[2];
    wire frame_start = rx_strobe & (rx_ctrl[`RX_FSTART_BIT] ? (fs_prev & ~fs_now) : (~fs_prev & fs_now));
    wire pck_new  = master ? o_pdm_clock_pin : (pck_agree ? sync_pck[2] : pck_lvl);
    wire pck_rise = ~pck_lvl & pck_new;
    wire pck_fall = pck_lvl & ~pck_new;
    // slot 0 may open on the very bit that carries the frame transition
    wire [4:0]  rx_offset = rx_ctrl[`RX_OFFSET_LSB+4:`RX_OFFSET_LSB];
    wire [8:0]  rx_pos    = frame_start ? 9'h000 : bit_cnt;
    wire        rx_take   = rx_strobe & (rx_pos >= {4'h0, rx_offset});
    wire [5:0]  cur_bit   = frame_start ? 6'h00 : slot_bit;
    wire [3:0]  cur_idx   = frame_start ? 4'h0 : slot_idx;
    wire        rx_sel    = (cur_idx == rx_ctrl[`RX_SLOT_LSB+3:`RX_SLOT_LSB]);

    always @* begin
        case (rx_ctrl[`RECEIVE_SLOT_LENGTH_LSB+1:`RECEIVE_SLOT_LENGTH_LSB])
            `SLEN_16: slot_len = 6'd16;
            `SLEN_24: slot_len = 6'd24;
            default:  slot_len = 6'd32;
        endcase
        // supported ratios, slot count from frame length
        case (frame_len)
            9'd64, 9'd96, 9'd128, 9'd192, 9'd256: ratio_ok = 1'b1;
            default: ratio_ok = 1'b0;
        endcase
        // frame period in system cycles sets the rate class
        if (fs_period > 13'd350)
            eff_rate = `SRATE_1X;
        else if (fs_period > 13'd170)
            eff_rate = `SRATE_2X;
        else
            eff_rate = `SRATE_4X;
        // manual rate must match measured rate
        rate_ok = rate_ctrl[`AUTO_RATE_BIT] ? (rate_ctrl[3:1] == eff_rate) : 1'b1;
        addr_ok = 1'b1;
        next_rdata = 32'h0000_0000;
        case (i_paddr)
            `OFF_PDM_CTRL:  next_rdata = {25'h000_0000, pdm_ctrl};
            `OFF_RX_CTRL:   next_rdata = {19'h0_0000, rx_ctrl};
            `OFF_RATE_CTRL: next_rdata = {28'h000_0000, rate_ctrl};
            // fault flag and measured values readable
            `OFF_STATUS:    next_rdata = {8'h00, 4'h0, slot_idx, o_volume, 3'h0, eff_rate[2:0], 1'b0, clock_fault} ;
            `OFF_PDM_DATA:  next_rdata = {26'h000_0000, o_pdm_sense_bits, o_pdm_play_bits, 2'b00};
            `OFF_RX_SAMPLE: next_rdata = o_play_sample;
            default:        addr_ok = 1'b0;
        endcase
    end

    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            pdm_ctrl <= `PDM_CTRL_RESET;
            rx_ctrl <= `RX_CTRL_RESET;
            rate_ctrl <= `RATE_CTRL_RESET;
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
            sync_bclk <= 3'h0;
            sync_fs <= 3'h0;
            sync_din <= 3'h0;
            sync_pck <= 3'h0;
            sync_pd <= 3'h0;
            bclk_lvl <= 1'b0;
            pck_lvl <= 1'b0;
            fs_prev <= 1'b0;
            bit_cnt <= 9'h000;
            frame_len <= 9'h000;
            frame_sys_cnt <= 9'h000;
            fs_period <= 13'h0000;
            shreg <= {SAMPLE_W{1'b0}};
            slot_bit <= 6'h00;
            slot_idx <= 4'h0;
            slot_pos <= 6'h00;
            pdm_rise_bit <= 1'b0;
            pdm_div <= 8'h00;
            ramp_cnt <= 8'h00;
            target_vol <= 8'hFF;
            clock_fault <= 1'b1;
            o_serial_data_out <= 1'b0;
            o_pdm_clock_pin <= 1'b0;
            o_pdm_clock_oe <= 1'b0;
            o_play_sample <= {SAMPLE_W{1'b0}};
            o_play_valid <= 1'b0;
            o_volume <= 8'h00;
            o_pdm_play_bits <= 2'b00;
            o_pdm_sense_bits <= 2'b00;
            o_pdm_valid <= 1'b0;
        end else begin
            // apb: one wait state, access answered in second access cycle
            o_pready <= apb_acc & ~o_pready;
            o_pslverr <= apb_acc & ~o_pready & ~addr_ok;
            if (apb_acc & ~o_pready & ~i_pwrite)
                o_prdata <= next_rdata;
            if (apb_wr & ~o_pready) begin
                case (i_paddr)
                    `OFF_PDM_CTRL:  pdm_ctrl <= i_pwdata[6:0];
                    `OFF_RX_CTRL:   rx_ctrl <= i_pwdata[12:0];
                    `OFF_RATE_CTRL: rate_ctrl <= i_pwdata[3:0];
                    default: ;
                endcase
            end
            sync_bclk <= {sync_bclk[1:0], i_serial_bit_clock};
            sync_fs <= {sync_fs[1:0], i_frame_sync};
            sync_din <= {sync_din[1:0], i_serial_data_in};
            sync_pck <= {sync_pck[1:0], i_pdm_clock_pin};
            sync_pd <= {sync_pd[1:0], i_pdm_data_pin};
            bclk_lvl <= bclk_new;
            pck_lvl <= pck_new;
            o_play_valid <= 1'b0;
            o_pdm_valid <= 1'b0;
            // sense path not part of this block, output held low
            o_serial_data_out <= 1'b0;
            frame_sys_cnt <= (frame_sys_cnt == 9'h1FF) ? frame_sys_cnt : frame_sys_cnt + 9'd1;
            if (rx_strobe) begin
                fs_prev <= fs_now;
                bit_cnt <= (bit_cnt == 9'h1FF) ? bit_cnt : bit_cnt + 9'd1;
            end
            if (frame_start) begin
                frame_len <= bit_cnt;
                bit_cnt <= 9'd1;
                fs_period <= {4'h0, frame_sys_cnt};
                frame_sys_cnt <= 9'h000;
                slot_bit <= 6'h00;
                slot_idx <= 4'h0;
                slot_pos <= 6'h00;
                shreg <= {SAMPLE_W{1'b0}};
                // fault on bad ratio or rate
                clock_fault <= ~(ratio_ok & rate_ok);
            end
            if (rx_take) begin
                if (rx_sel) begin
                    shreg[SAMPLE_W-1-cur_bit] <= sync_din[2];
                    slot_pos <= cur_bit + 6'd1;
                end
                if (cur_bit == slot_len - 6'd1) begin
                    slot_bit <= 6'h00;
                    if (rx_sel) begin
                        o_play_sample <= {shreg[SAMPLE_W-1:1], 1'b0} | (sync_din[2] ? ({{(SAMPLE_W-1){1'b0}}, 1'b1} << (SAMPLE_W-1-cur_bit)) : {SAMPLE_W{1'b0}});
                        o_play_valid <= 1'b1;
                    end
                    slot_idx <= cur_idx + 4'h1;
                end else begin
                    slot_bit <= cur_bit + 6'd1;
                end
            end
            // slot cut or never reached in the frame plays as mute
            if (frame_start & (slot_pos != slot_len)) begin
                o_play_sample <= {SAMPLE_W{1'b0}};
                o_play_valid <= 1'b1;
            end
            ramp_cnt <= (ramp_cnt == `RAMP_STEP) ? 8'h00 : ramp_cnt + 8'h01;
            if (ramp_cnt == `RAMP_STEP) begin
                if (clock_fault) begin
                    if (o_volume != 8'h00)
                        o_volume <= o_volume - 8'h01;
                end else if (o_volume < target_vol) begin
                    o_volume <= o_volume + 8'h01;
                end else begin
                    o_volume <= target_vol;
                end
            end
            o_pdm_clock_oe <= master;
            if (master & pdm_ctrl[`PDM_MASTER_CLOCK_GATE_BIT]) begin
                if (pdm_div == 8'h01) begin
                    pdm_div <= (pdm_ctrl[`PDM_RATE_LSB+1:`PDM_RATE_LSB] == 2'b01) ? `PDM_HALF_2X : `PDM_HALF_1X;
                    o_pdm_clock_pin <= ~o_pdm_clock_pin;
                end else begin
                    pdm_div <= (pdm_div == 8'h00) ? `PDM_HALF_1X : pdm_div - 8'h01;
                end
            end else begin
                pdm_div <= 8'h00;
                o_pdm_clock_pin <= 1'b0;
            end
            if (pdm_ctrl[`PDM_CLKSEL_BIT]) begin
                // first channel on selected edge, second on the other
                if (pdm_ctrl[`PDM_CAPTURE_EDGE_SEL_BIT] ? pck_fall : pck_rise)
                    pdm_rise_bit <= sync_pd[2];
                if (pdm_ctrl[`PDM_CAPTURE_EDGE_SEL_BIT] ? pck_rise : pck_fall) begin
                    if (pdm_ctrl[`PDM_PIN_ROLE_SELECT_BIT])
                        o_pdm_play_bits <= {pdm_rise_bit, sync_pd[2]};
                    else
                        o_pdm_sense_bits <= {pdm_rise_bit, sync_pd[2]};
                    o_pdm_valid <= 1'b1;
                end
            end
        end
    end
endmodule

//--- verification/audio_input_port_props.sv
`timescale 1ns/10ps
module audio_port_checker (
    input wire        i_clock,           // system clock
    input wire        i_reset_n,         // sync reset, low
    input wire        i_psel,            // apb select
    input wire        i_penable,         // apb enable
    input wire        i_pwrite,          // apb write
    input wire        o_pready,          // apb ready
    input wire [31:0] o_prdata,          // apb read data
    input wire        o_pslverr,         // apb error
    input wire        o_serial_data_out, // sense stream
    input wire        o_pdm_clock_pin,   // pdm clock out
    input wire        o_pdm_clock_oe,    // pdm clock enable
    input wire        o_play_valid,      // sample strobe
    input wire [7:0]  o_volume,          // ramped gain
    input wire        o_pdm_valid        // pdm pair strobe
);
    reg [3:0] high_run;
    // counts the high cycles seen so far in a master clock phase
    always @(posedge i_clock) begin
        if (!i_reset_n || !o_pdm_clock_pin)
            high_run <= 4'h0;
        else
            high_run <= high_run + 4'h1;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    property p_ready_lat; i_psel && i_penable && !o_pready |=> o_pready; endproperty
    property p_ready_one; o_pready |=> !o_pready; endproperty
    property p_err_zero; o_pready && o_pslverr && !i_pwrite |-> o_prdata == 32'h0000_0000; endproperty
    property p_serial_data_out_zero; o_serial_data_out == 1'b0; endproperty
    property p_duty; o_pdm_clock_oe && o_pdm_clock_pin |-> high_run <= 4'h3; endproperty
    property p_vol_step;
        $changed(o_volume) |-> o_volume == $past(o_volume) + 8'h01 || o_volume == $past(o_volume) - 8'h01;
    endproperty
    property p_vol_hold; $changed(o_volume) |=> $stable(o_volume) [*8]; endproperty
    property p_play_pulse; o_play_valid |=> !o_play_valid; endproperty
    property p_pdm_pulse; o_pdm_valid |=> !o_pdm_valid [*3]; endproperty
    property p_reset;
        disable iff (1'b0) !i_reset_n |=> o_volume == 8'h00 && !o_pdm_clock_oe && !o_play_valid;
    endproperty
    a_ready_lat: assert property (p_ready_lat) else $error("ready late");
    a_ready_one: assert property (p_ready_one) else $error("ready too long");
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    a_serial_data_out_zero: assert property (p_serial_data_out_zero) else $error("sense line active");
    a_duty: assert property (p_duty) else $error("pdm clock high too long");
    a_vol_step: assert property (p_vol_step) else $error("volume jumped");
    a_vol_hold: assert property (p_vol_hold) else $error("volume ramp too fast");
    a_play_pulse: assert property (p_play_pulse) else $error("sample strobe long");
    a_pdm_pulse: assert property (p_pdm_pulse) else $error("pdm strobe too often");
    a_reset: assert property (p_reset) else $error("reset state wrong");
    c_play: cover property (o_play_valid);
    c_master: cover property (o_pdm_clock_oe && o_pdm_clock_pin);
    c_err: cover property (o_pslverr);
endmodule

bind audio_input_port audio_port_checker chk (.i_clock, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .o_pready,
    .o_prdata, .o_pslverr, .o_serial_data_out, .o_pdm_clock_pin, .o_pdm_clock_oe, .o_play_valid, .o_volume,
    .o_pdm_valid);

//--- verification/audio_host_model.sv
`timescale 1ns/10ps
module audio_host_model (
    input  wire        i_run,      // frames while high
    input  wire [8:0]  i_ratio,    // bit clocks per frame
    input  wire [4:0]  i_offset,   // bits before slot 0
    input  wire        i_fstart,   // 1: frame opens high to low
    input  wire        i_fall,     // device captures on falling edge
    input  wire [31:0] i_word,     // slot 0 word
    output logic       o_bclk,     // serial bit clock
    output logic       o_frame_sync,    // frame sync
    output logic       o_serial_data_in,     // serial data
    output logic       o_pdm_sample_clock_sel,  // pdm clock
    output logic       o_pdm_data  // pdm data
);
    int b;
    initial begin
        {o_bclk, o_frame_sync, o_serial_data_in, o_pdm_sample_clock_sel, o_pdm_data} = 5'h00;
        forever begin
            // clocks stand still between runs, data keeps moving
            while (!i_run) begin
                #200;
                o_serial_data_in = ~o_serial_data_in;
                o_pdm_data = ~o_pdm_data;
            end
            for (b = 0; b < i_ratio; b++) begin
                o_bclk = i_fall;
                o_pdm_sample_clock_sel = 1'b0;
                o_frame_sync = (b < i_ratio / 2) ? !i_fstart : i_fstart;
                o_serial_data_in = i_word[31 - ((b - i_offset) & 31)] ^ (b < i_offset || b >= i_offset + 32);
                #100;
                o_pdm_data = 1'b1;
                #100;
                o_bclk = !i_fall;
                o_pdm_sample_clock_sel = 1'b1;
                #100;
                o_pdm_data = 1'b0;
                #100;
            end
        end
    end
endmodule

//--- verification/tdm_pdm_audio_input_port_bench.sv
`timescale 1ns/10ps
`include "audio_port_regs.vh"
module tdm_pdm_audio_input_port_bench;
    logic        i_clock, i_reset_n, i_psel, i_penable, i_pwrite, run, fstart, fall, err;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata, q, word;
    logic [8:0]  ratio;
    logic [4:0]  offset;
    logic [12:0] rxv [5] = '{13'h000A, 13'h0011, 13'h0016, 13'h0058, 13'h01F3};
    logic [8:0]  rt [5]  = '{9'h040, 9'h060, 9'h080, 9'h0C0, 9'h100};
    wire  [31:0] o_prdata, o_play_sample;
    wire  [7:0]  o_volume;
    wire  [1:0]  play_bits, sense_bits;
    wire         o_pready, o_pslverr, play_valid, pdm_valid, pdm_out, pdm_oe, bclk, frame_sync, serial_data_in, m_pclk, pdata;
    wire         pdm_wire = pdm_oe ? pdm_out : m_pclk;
    int          bad_count = 0, checked = 0, cyc = 0;
    audio_input_port dut (.i_clock, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready,
        .o_prdata, .o_pslverr, .i_serial_bit_clock(bclk), .i_frame_sync(frame_sync), .i_serial_data_in(serial_data_in),
        .o_serial_data_out(), .i_pdm_clock_pin(pdm_wire), .o_pdm_clock_pin(pdm_out), .o_pdm_clock_oe(pdm_oe),
        .i_pdm_data_pin(pdata), .o_play_sample, .o_play_valid(play_valid), .o_volume,
        .o_pdm_play_bits(play_bits), .o_pdm_sense_bits(sense_bits), .o_pdm_valid(pdm_valid));
    audio_host_model host (.i_run(run), .i_ratio(ratio), .i_offset(offset), .i_fstart(fstart), .i_fall(fall),
        .i_word(word), .o_bclk(bclk), .o_frame_sync(frame_sync), .o_serial_data_in(serial_data_in), .o_pdm_sample_clock_sel(m_pclk), .o_pdm_data(pdata));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        i_psel    <= 1'b1;
        i_pwrite  <= w;
        i_paddr   <= a;
        i_pwdata  <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_pready !== 1'b1);
        q = o_prdata;
        err = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clock);
    endtask
    task wait_ev(input logic pdm, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while ((pdm ? pdm_valid : play_valid) !== 1'b1 && n < lim);
    endtask
    task wait_vol(input logic up, input int lim);
        int n;
        n = 0;
        while ((o_volume === 8'hFF) !== up && n < lim) begin
            @(posedge i_clock);
            n++;
        end
    endtask
    task run_len(input logic lvl, output int n);
        n = 0;
        while (pdm_out === lvl && n < 60) begin
            @(posedge i_clock);
            n++;
        end
    endtask
    task t_reset;
        apb(`OFF_PDM_CTRL, 1'b0, 32'h0);
        chk("pdm_ctrl", q, 32'h0000_0008);
        apb(`OFF_RX_CTRL, 1'b0, 32'h0);
        chk("rx_ctrl", q, 32'h0000_000A);
        apb(`OFF_RATE_CTRL, 1'b0, 32'h0);
        chk("rate_ctrl", q, 32'h0000_0006);
        apb(8'h20, 1'b0, 32'h0);
        chk("unmapped", {err, q[30:0]}, 32'h8000_0000);
        $display("test reset done");
    endtask
    task t_pcm;
        logic [31:0] m;
        for (int i = 0; i < 5; i++) begin
            apb(`OFF_RX_CTRL, 1'b1, {19'h0, rxv[i]});
            ratio  <= rt[i];
            offset <= rxv[i][8:4];
            fstart <= rxv[i][1];
            fall   <= rxv[i][0];
            word   <= word + 32'h1357_9BDF;
            m = rxv[i][3:2] == 2'h0 ? 32'hFFFF_0000 : rxv[i][3:2] == 2'h1 ? 32'hFFFF_FF00 : 32'hFFFF_FFFF;
            repeat (4) wait_ev(1'b0, 4500);
            chk("play_sample", o_play_sample, word & m);
        end
        apb(`OFF_RX_CTRL, 1'b1, 32'h0000_040A);
        ratio  <= 9'h040;
        offset <= 5'h00;
        fstart <= 1'b1;
        fall   <= 1'b0;
        repeat (3) wait_ev(1'b0, 1600);
        apb(`OFF_RX_SAMPLE, 1'b0, 32'h0);
        chk("null_sample", q, 32'h0);
        apb(`OFF_RX_CTRL, 1'b1, 32'h0000_000A);
        $display("test pcm done");
    endtask
    task t_fault;
        wait_vol(1'b1, 9000);
        chk("volume_up", o_volume, 8'hFF);
        ratio <= 9'h050;
        wait_vol(1'b0, 3000);
        apb(`OFF_STATUS, 1'b0, 32'h0);
        chk("fault_set", q[0], 1'b1);
        ratio <= 9'h040;
        wait_vol(1'b1, 9000);
        apb(`OFF_STATUS, 1'b0, 32'h0);
        chk("fault_clear", {q[4:2], q[0]}, 4'h6);
        apb(`OFF_RATE_CTRL, 1'b1, 32'h0000_0009);
        wait_vol(1'b0, 3000);
        apb(`OFF_STATUS, 1'b0, 32'h0);
        chk("manual_fault", q[0], 1'b1);
        apb(`OFF_RATE_CTRL, 1'b1, 32'h0000_0007);
        repeat (3) wait_ev(1'b0, 1600);
        apb(`OFF_STATUS, 1'b0, 32'h0);
        chk("manual_ok", q[0], 1'b0);
        $display("test fault done");
    endtask
    task t_pdm;
        int h, l;
        for (int i = 0; i < 4; i++) begin
            apb(`OFF_PDM_CTRL, 1'b1, {25'h0, i[1], 5'h04, i[0]});
            repeat (3) wait_ev(1'b1, 200);
            chk("pdm_bits", i[1] ? play_bits : sense_bits, i[0] ? 2'h1 : 2'h2);
        end
        apb(`OFF_PDM_CTRL, 1'b1, 32'h0);
        repeat (10) @(posedge i_clock);
        wait_ev(1'b1, 100);
        chk("pdm_off", pdm_valid, 1'b0);
        for (int i = 0; i < 2; i++) begin
            apb(`OFF_PDM_CTRL, 1'b1, {27'h0, i[0], 4'hE});
            run_len(1'b1, h);
            run_len(1'b0, h);
            run_len(1'b1, h);
            run_len(1'b0, l);
            chk("pdm_high", h, i ? 2 : 4);
            chk("pdm_low", l, i ? 2 : 4);
        end
        apb(`OFF_PDM_CTRL, 1'b1, 32'h0000_000A);
        repeat (10) @(posedge i_clock);
        run_len(1'b0, l);
        chk("pdm_gated", {pdm_oe, l[30:0]}, 32'h8000_003C);
        apb(`OFF_PDM_CTRL, 1'b1, 32'h0000_0008);
        @(posedge i_clock);
        chk("pdm_slave", pdm_oe, 1'b0);
        $display("test pdm done");
    endtask
    task test_done;
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    // ceiling well above the roughly 30k cycles the tests need
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            bad_count++;
            test_done;
        end
    end
    initial begin
        {i_reset_n, i_psel, i_penable, i_pwrite, run, fall} = 6'h00;
        {i_paddr, i_pwdata, word} = {8'h00, 32'h0, 32'h9E37_79B9};
        {ratio, offset, fstart} = {9'h040, 5'h00, 1'b1};
        repeat (8) @(posedge i_clock);
        i_reset_n <= 1'b1;
        @(posedge i_clock);
        t_reset;
        run <= 1'b1;
        t_pcm;
        t_fault;
        t_pdm;
        test_done;
    end
endmodule
